// file: rtl/cdck_pkg.sv
// package: register map, field layout and timing constants of the decoder clock control
package cdck_pkg;
  // register byte addresses (relative to the decoder base)
  localparam logic [11:0] CDCK_OWN_LAST      = 12'h24C;
  localparam logic [11:0] CDCK_HOST_FIRST    = 12'h2A0;
  localparam logic [11:0] CDCK_HOST_LAST     = 12'h374;
  localparam logic [11:0] CDCK_ADDR_PLL      = 12'h200;
  localparam logic [11:0] CDCK_ADDR_CORE     = 12'h204;
  localparam logic [11:0] CDCK_ADDR_BITCLK   = 12'h208;
  localparam logic [11:0] CDCK_ADDR_SPDIF    = 12'h20C;
  localparam logic [11:0] CDCK_ADDR_DEBUG    = 12'h210;
  localparam logic [11:0] CDCK_ADDR_SERIAL   = 12'h214;
  localparam logic [11:0] CDCK_ADDR_STATUS   = 12'h218;
  localparam int          CDCK_HOST_WORDS    = 62;
  // field positions
  localparam int          CDCK_BIT_CRYSTAL_16M_SELECT     = 0;
  localparam int          CDCK_BIT_SLEEP     = 7;
  localparam int          CDCK_BIT_GATE      = 7;
  localparam int          CDCK_BIT_SLAVE     = 0;
  localparam int          CDCK_BIT_BCLK_RX   = 1;
  localparam int          CDCK_DIV_W         = 3;
  localparam int          CDCK_WIDE_DIV_W    = 7;
  // reset values
  localparam logic [7:0]  CDCK_RST_PLL       = 8'h00;
  localparam logic [7:0]  CDCK_RST_CORE      = 8'h02;
  localparam logic [7:0]  CDCK_RST_BITCLK    = 8'h17;
  localparam logic [7:0]  CDCK_RST_SPDIF     = 8'h05;
  localparam logic [7:0]  CDCK_RST_DEBUG     = 8'h11;
  localparam logic [7:0]  CDCK_RST_SERIAL    = 8'h00;
  localparam logic [7:0]  CDCK_ZERO_BYTE     = 8'h00;
  localparam logic [31:0] CDCK_ZERO_WORD     = 32'h0000_0000;
  // master clock figures, kHz
  localparam int          CDCK_XTAL_KHZ      = 8467;
  localparam int          CDCK_MULT          = 8;
endpackage : cdck_pkg

// file: rtl/cdck_clock_control.sv
// module: decoder clock control with register port
`timescale 1ns/1ps
// =========================================================
// What this block does
// [RL1] generate four clock domains: master, core, audio bit, S/PDIF
// [RL2] master clock 67.7376 MHz from 8.4672 MHz crystal times eight
// [RL3] 16 MHz select halves crystal; software sets it to match crystal
// [RL4] core clock is master divided by two, 50 percent duty
// [RL5] core clock divided further by system clock divider field
// [RL6] core config register holds sleep control stopping core, debug line and external DAC clocks
// [RL7] software keeps RF bit rate over core clock within 0.25 to 2
// [RL8] software keeps RF bit rate over core clock at most 1.7
// [RL9] audio bit clock runs serial back end and is driven out
// [RL10] slave mode: software sets bit clock 44100 x 2 x slot width
// [RL11] gated master mode: bit clock above output rate, 2.8224 MHz for 32-bit
// [RL12] bit clock register selects divider and holds gating enable
// [RL13] S/PDIF back end enabled only in audio slave mode
// [RL14] software sets S/PDIF clock to 44100 x 64 = 2.8224 MHz
// [RL15] RF sample clock fixed at master clock rate, captures converter samples
// [RL16] receive mode uses external bit clock input instead of own
// [RL17] debug line clock frequency set in debug clock register
// [RL18] external DAC clock frequency set in debug clock register
// [RL19] registers reachable through the processor slave port
// [RL20] 8-bit registers in 32-bit slots, upper 24 bits zero
// [RL21] own registers decode within 0x000 to 0x24C
// [RL22] hosted registers at 0x2A0 to 0x374, no effect on decoder
// [RL23] divider and gating changes take effect at divided-clock boundary
module cdck_clock_control
  import cdck_pkg::*;
#(
  parameter int HOST_WORDS = CDCK_HOST_WORDS
) (
  input  wire logic        mclk,
  input  wire logic        srst,
  input  wire logic [11:0] reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  input  wire logic        xtal_ref,
  input  wire logic        ext_bit_clock,
  output logic             pll_ref_en,
  output logic             core_clock_en,
  output logic             bit_clock_en,
  output logic             bit_clock_out,
  output logic             spdif_clock_en,
  output logic             spdif_enable,
  output logic             rf_sample_clock_en,
  output logic             debug_line_clock,
  output logic             external_dac_clock,
  output logic             crystal_16m_select,
  output logic             sleep_state
);

  // =========================================================
  // registers
  logic [7:0] analog_pll_control_reg;
  logic [7:0] core_clock_config_reg;
  logic [7:0] audio_bit_clock_config_reg;
  logic [7:0] spdif_clock_config_reg;
  logic [7:0] debug_clock_config_reg;
  logic [7:0] audio_serial_config_reg;
  logic [7:0] host_reg [HOST_WORDS];

  function automatic logic in_own(input logic [11:0] a);
    in_own = (a <= CDCK_OWN_LAST) && (a[1:0] == 2'b00); // RL21
  endfunction : in_own

  function automatic logic in_host(input logic [11:0] a);
    in_host = (a >= CDCK_HOST_FIRST) && (a <= CDCK_HOST_LAST) && (a[1:0] == 2'b00); // RL22
  endfunction : in_host

  // offset only means something inside the hosted window
  logic [11:0] host_off;
  logic [5:0]  host_idx;
  assign host_off = reg_addr - CDCK_HOST_FIRST;
  assign host_idx = host_off[7:2];

  always_ff @(posedge mclk) begin
    if (srst) begin
      analog_pll_control_reg     <= CDCK_RST_PLL;
      core_clock_config_reg      <= CDCK_RST_CORE;
      audio_bit_clock_config_reg <= CDCK_RST_BITCLK;
      spdif_clock_config_reg     <= CDCK_RST_SPDIF;
      debug_clock_config_reg     <= CDCK_RST_DEBUG;
      audio_serial_config_reg    <= CDCK_RST_SERIAL;
    end else if (reg_wr && in_own(reg_addr)) begin // RL19
      case (reg_addr)
        CDCK_ADDR_PLL:    analog_pll_control_reg     <= reg_wdata[7:0];
        CDCK_ADDR_CORE:   core_clock_config_reg      <= reg_wdata[7:0];
        CDCK_ADDR_BITCLK: audio_bit_clock_config_reg <= reg_wdata[7:0];
        CDCK_ADDR_SPDIF:  spdif_clock_config_reg     <= reg_wdata[7:0];
        CDCK_ADDR_DEBUG:  debug_clock_config_reg     <= reg_wdata[7:0];
        CDCK_ADDR_SERIAL: audio_serial_config_reg    <= reg_wdata[7:0];
        default: ;
      endcase
    end
  end

  // hosted bytes only store; nothing but the read port reads them
  always_ff @(posedge mclk) begin
    if (srst) begin
      for (int i = 0; i < HOST_WORDS; i++) host_reg[i] <= CDCK_ZERO_BYTE;
    end else if (reg_wr && in_host(reg_addr)) begin
      host_reg[host_idx] <= reg_wdata[7:0]; // RL22
    end
  end

  // =========================================================
  // read port: data in the cycle after the strobe only
  logic [7:0] next_rbyte;
  always_comb begin
    next_rbyte = CDCK_ZERO_BYTE;
    if (in_host(reg_addr)) next_rbyte = host_reg[host_idx];
    else begin
      case (reg_addr)
        CDCK_ADDR_PLL:    next_rbyte = analog_pll_control_reg;
        CDCK_ADDR_CORE:   next_rbyte = core_clock_config_reg;
        CDCK_ADDR_BITCLK: next_rbyte = audio_bit_clock_config_reg;
        CDCK_ADDR_SPDIF:  next_rbyte = spdif_clock_config_reg;
        CDCK_ADDR_DEBUG:  next_rbyte = debug_clock_config_reg;
        CDCK_ADDR_SERIAL: next_rbyte = audio_serial_config_reg;
        CDCK_ADDR_STATUS: next_rbyte = {4'h0, spdif_enable, sleep_state,
                                        bit_clock_out, core_clock_en};
        default:          next_rbyte = CDCK_ZERO_BYTE;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) reg_rdata <= CDCK_ZERO_WORD;
    else if (reg_rd) reg_rdata <= {24'h000000, next_rbyte}; // RL20
    else reg_rdata <= CDCK_ZERO_WORD;
  end

  // =========================================================
  // master clock stage: mclk stands for the multiplied master clock
  logic xtal_half;
  always_ff @(posedge mclk) begin
    if (srst) xtal_half <= 1'b0;
    else xtal_half <= ~xtal_half;
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      crystal_16m_select <= 1'b0;
      pll_ref_en         <= 1'b0;
      rf_sample_clock_en <= 1'b0;
    end else begin
      crystal_16m_select <= analog_pll_control_reg[CDCK_BIT_CRYSTAL_16M_SELECT];
      // 16 MHz crystal: reference passes every second edge only
      pll_ref_en <= xtal_ref & (~analog_pll_control_reg[CDCK_BIT_CRYSTAL_16M_SELECT] | xtal_half); // RL3
      rf_sample_clock_en <= 1'b1; // RL15 RL2
    end
  end

  // =========================================================
  // core clock: master / 2, then / 2^div; sleep stops it
  // 8-bit count: exponent 7 needs a 256-cycle period
  logic [7:0]            core_cnt;
  logic [CDCK_DIV_W-1:0] core_div;
  logic                  core_sleep;
  logic [7:0]            core_top;
  assign core_top = 8'((2 << core_div) - 1); // RL4 RL5
  always_ff @(posedge mclk) begin
    if (srst) begin
      core_cnt      <= '0;
      core_div      <= CDCK_RST_CORE[CDCK_DIV_W-1:0];
      core_sleep    <= 1'b0;
      core_clock_en <= 1'b0;
      sleep_state   <= 1'b0;
    end else begin
      core_clock_en <= (core_cnt == core_top) & ~core_sleep; // RL1 RL6
      sleep_state   <= core_sleep;
      if (core_cnt >= core_top) begin
        core_cnt   <= '0;
        core_div   <= core_clock_config_reg[CDCK_DIV_W-1:0]; // RL23
        core_sleep <= core_clock_config_reg[CDCK_BIT_SLEEP];
      end else core_cnt <= core_cnt + 8'h01;
    end
  end

  // =========================================================
  // programmable dividers share one shape: toggle per (div+1) master cycles
  logic [7:0] div_cfg [4];
  logic [3:0] div_run;
  logic [3:0] div_lvl;
  logic [3:0] div_tick;
  assign div_cfg[0] = audio_bit_clock_config_reg;
  assign div_cfg[1] = spdif_clock_config_reg;
  assign div_cfg[2] = {4'h0, debug_clock_config_reg[3:0]};
  assign div_cfg[3] = {4'h0, debug_clock_config_reg[7:4]};
  // debug and dac clocks (indices 2, 3) are among those stopped in sleep
  assign div_run = {~core_sleep, ~core_sleep, 1'b1, 1'b1};

  for (genvar g = 0; g < 4; g++) begin : g_div
    logic [6:0] cnt;
    logic [6:0] top;
    always_ff @(posedge mclk) begin
      if (srst) begin
        cnt         <= '0;
        top         <= '0;
        div_lvl[g]  <= 1'b0;
        div_tick[g] <= 1'b0;
      end else begin
        div_tick[g] <= 1'b0;
        if (cnt >= top) begin
          cnt <= '0;
          // new ratio only loads at the half-period boundary
          top <= div_cfg[g][CDCK_WIDE_DIV_W-1:0]; // RL23 RL12 RL17 RL18
          if (div_run[g]) begin
            div_lvl[g]  <= ~div_lvl[g];
            div_tick[g] <= ~div_lvl[g];
          end
        end else cnt <= cnt + 7'h01;
      end
    end
  end

  // =========================================================
  // audio bit clock, S/PDIF and debug outputs
  logic gate_on;
  logic rx_mode;
  always_ff @(posedge mclk) begin
    if (srst) begin
      gate_on <= 1'b0;
      rx_mode <= 1'b0;
    end else if (~div_lvl[0]) begin
      // low phase only: switching here cannot clip a high pulse
      gate_on <= audio_bit_clock_config_reg[CDCK_BIT_GATE]; // RL23 RL12
      rx_mode <= audio_serial_config_reg[CDCK_BIT_BCLK_RX];
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      bit_clock_out      <= 1'b0;
      bit_clock_en       <= 1'b0;
      spdif_clock_en     <= 1'b0;
      spdif_enable       <= 1'b0;
      debug_line_clock   <= 1'b0;
      external_dac_clock <= 1'b0;
    end else begin
      bit_clock_out  <= rx_mode ? ext_bit_clock : (div_lvl[0] & ~gate_on); // RL9 RL16
      bit_clock_en   <= ~rx_mode & div_tick[0] & ~gate_on;               // RL1
      spdif_enable   <= audio_serial_config_reg[CDCK_BIT_SLAVE];          // RL13
      spdif_clock_en <= div_tick[1] & audio_serial_config_reg[CDCK_BIT_SLAVE]; // RL13
      debug_line_clock   <= div_lvl[2];                                   // RL17
      external_dac_clock <= div_lvl[3];                                   // RL18
    end
  end

  // =========================================================
  // checks
  // register port
  a_rdata_high_zero: assert property (@(posedge mclk) disable iff (srst) // RL20
    reg_rdata[31:8] == 24'h000000) else $error("upper read bits not zero");
  a_rdata_idle: assert property (@(posedge mclk) disable iff (srst) // RL19
    !$past(reg_rd) |-> reg_rdata == CDCK_ZERO_WORD) else $error("read data outside slot");
  a_rdata_core: assert property (@(posedge mclk) disable iff (srst) // RL19
    ($past(reg_rd) && $past(reg_addr) == CDCK_ADDR_CORE) |->
    reg_rdata[7:0] == $past(core_clock_config_reg))
    else $error("core register read wrong");
  a_host_isolated: assert property (@(posedge mclk) disable iff (srst) // RL22
    (reg_wr && in_host(reg_addr)) |=> $stable(core_clock_config_reg))
    else $error("hosted write reached decoder register");
  // clock domains
  a_spdif_slave: assert property (@(posedge mclk) disable iff (srst) // RL13
    spdif_clock_en |-> spdif_enable) else $error("spdif clock outside slave mode");
  a_sleep_core: assert property (@(posedge mclk) disable iff (srst) // RL6
    sleep_state |=> !core_clock_en) else $error("core clock during sleep");
  a_sleep_debug: assert property (@(posedge mclk) disable iff (srst) // RL6
    (sleep_state && $past(sleep_state)) |->
    ($stable(debug_line_clock) && $stable(external_dac_clock)))
    else $error("debug clocks run in sleep");
  a_core_space: assert property (@(posedge mclk) disable iff (srst) // RL4
    core_clock_en |=> !core_clock_en) else $error("core clock not divided");
  a_core_hold: assert property (@(posedge mclk) disable iff (srst) // RL23
    (core_cnt < core_top) |=> $stable(core_div))
    else $error("core divider changed mid-period");
  a_gate_bitclk: assert property (@(posedge mclk) disable iff (srst) // RL12
    ($past(gate_on) && !$past(rx_mode)) |-> !bit_clock_out)
    else $error("gated bit clock moved");
  a_gate_edge: assert property (@(posedge mclk) disable iff (srst) // RL23
    div_lvl[0] |=> ($stable(gate_on) && $stable(rx_mode)))
    else $error("bit clock mode changed in high phase");
  a_bitclk_rise: assert property (@(posedge mclk) disable iff (srst) // RL9
    bit_clock_en |-> bit_clock_out) else $error("bit clock pulse without high level");
  a_rx_follow: assert property (@(posedge mclk) disable iff (srst) // RL16
    ($past(rx_mode) && rx_mode) |-> bit_clock_out == $past(ext_bit_clock))
    else $error("receive bit clock not followed");
  a_crystal_16m_select_ref: assert property (@(posedge mclk) disable iff (srst) // RL3
    (analog_pll_control_reg[CDCK_BIT_CRYSTAL_16M_SELECT] && !xtal_half) |=> !pll_ref_en)
    else $error("reference not halved");
  a_pll_full: assert property (@(posedge mclk) disable iff (srst) // RL3
    (!analog_pll_control_reg[CDCK_BIT_CRYSTAL_16M_SELECT] && xtal_ref) |=> pll_ref_en)
    else $error("reference not passed");
  a_rf_clock: assert property (@(posedge mclk) disable iff (srst) // RL15
    $past(srst) == 1'b0 |-> rf_sample_clock_en) else $error("rf sample clock missing");
  c_sleep: cover property (@(posedge mclk) disable iff (srst) $rose(sleep_state));
  c_gate: cover property (@(posedge mclk) disable iff (srst) $rose(gate_on));
  c_rx: cover property (@(posedge mclk) disable iff (srst) $rose(rx_mode));
  c_spdif: cover property (@(posedge mclk) disable iff (srst) spdif_clock_en);
  c_host_rd: cover property (@(posedge mclk) disable iff (srst) reg_rd && in_host(reg_addr));

endmodule : cdck_clock_control

// file: testbench/cdck_host_model.sv
// bench model of the processor master on the register port
`timescale 1ns/1ps
// ==========================================================
// register master and external bit clock source
module cdck_host_model (
  input  wire logic        mclk,
  input  wire logic        ext_run,
  input  wire logic [31:0] reg_rdata,
  output logic      [11:0] reg_addr,
  output logic      [31:0] reg_wdata,
  output logic             reg_wr,
  output logic             reg_rd,
  output logic             ext_bit_clock
);
  int ph;
  initial begin
    reg_addr = 12'h000;
    reg_wdata = 32'h0000_0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    ext_bit_clock = 1'b0;
    ph = 0;
  end
  // external bit clock stands still unless a frame is running
  always @(posedge mclk) begin
    if (ext_run) begin
      ph = (ph + 1) % 3;
      if (ph == 0) ext_bit_clock <= ~ext_bit_clock;
    end
  end
  // upper bytes are garbage on purpose: only the low byte counts
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= {24'hFFFFFF, d};
    @(posedge mclk);
    reg_wr <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= {24'h000000, ~d};
  endtask : wr
  task automatic rd(input logic [11:0] a, output logic [31:0] d);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    #1 d = reg_rdata;
  endtask : rd
endmodule : cdck_host_model

// file: testbench/tb_top.sv
// self-checking bench for the decoder clock control
`timescale 1ns/1ps
// ==========================================================
// clock, reset, design and master
module tb_top;
  import cdck_pkg::*;
  logic mclk, srst, xtal_ref, ext_run, ext_bit_clock, reg_wr, reg_rd, clr, rx_chk;
  logic [11:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, rv;
  logic pll_ref_en, core_clock_en, bit_clock_en, bit_clock_out, spdif_clock_en;
  logic spdif_enable, rf_sample_clock_en, debug_line_clock, external_dac_clock;
  logic crystal_16m_select, sleep_state, dbg_q, dac_q, ext_q, bo_q;
  int n_mismatch, n_tests, c_core, c_bit, c_sp, c_pll, c_dbg, c_dac, c_bo, rx_err;
  logic [11:0] ra [6] = '{CDCK_ADDR_PLL, CDCK_ADDR_CORE, CDCK_ADDR_BITCLK,
                          CDCK_ADDR_SPDIF, CDCK_ADDR_DEBUG, CDCK_ADDR_SERIAL};
  logic [7:0] rr [6] = '{CDCK_RST_PLL, CDCK_RST_CORE, CDCK_RST_BITCLK,
                         CDCK_RST_SPDIF, CDCK_RST_DEBUG, CDCK_RST_SERIAL};
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  cdck_clock_control dut_u (.mclk(mclk), .srst(srst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .xtal_ref(xtal_ref), .ext_bit_clock(ext_bit_clock), .pll_ref_en(pll_ref_en),
    .core_clock_en(core_clock_en), .bit_clock_en(bit_clock_en),
    .bit_clock_out(bit_clock_out), .spdif_clock_en(spdif_clock_en),
    .spdif_enable(spdif_enable), .rf_sample_clock_en(rf_sample_clock_en),
    .debug_line_clock(debug_line_clock), .external_dac_clock(external_dac_clock),
    .crystal_16m_select(crystal_16m_select), .sleep_state(sleep_state));
  cdck_host_model host (.mclk(mclk), .ext_run(ext_run), .reg_rdata(reg_rdata),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .ext_bit_clock(ext_bit_clock));
  // ==========================================================
  // edge and pulse counters over a measuring span
  always @(posedge mclk) begin
    if (clr) begin
      {c_core, c_bit, c_sp, c_pll, c_dbg, c_dac, c_bo, rx_err} = '0;
    end else begin
      c_core += int'(core_clock_en);
      c_bit += int'(bit_clock_en);
      c_sp += int'(spdif_clock_en);
      c_pll += int'(pll_ref_en);
      c_dbg += int'(debug_line_clock !== dbg_q);
      c_dac += int'(external_dac_clock !== dac_q);
      c_bo += int'(bit_clock_out !== bo_q);
      if (rx_chk && bit_clock_out !== ext_q) rx_err++;
    end
    {dbg_q, dac_q, ext_q, bo_q} = {debug_line_clock, external_dac_clock, ext_bit_clock,
                                   bit_clock_out};
  end
  // ==========================================================
  // checking tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check
  task automatic rd_chk(input logic [11:0] a, input logic [7:0] exp);
    host.rd(a, rv);
    check(rv, {24'h000000, exp}, "read data");
  endtask : rd_chk
  // settle past the next divided-clock boundary, then count n cycles
  task automatic measure(input int n);
    repeat (60) @(posedge mclk);
    clr <= 1'b1;
    @(posedge mclk);
    clr <= 1'b0;
    repeat (n) @(posedge mclk);
    #1;
  endtask : measure
  task automatic print_verdict;
    $display("mismatches %0d comparisons %0d", n_mismatch, n_tests);
    if (n_mismatch == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : print_verdict
  initial begin
    repeat (8000) @(posedge mclk);
    n_mismatch++;
    print_verdict();
  end
  // ==========================================================
  // scenarios
  initial begin
    {srst, xtal_ref, ext_run, clr, rx_chk} = 5'b11010;
    repeat (5) @(posedge mclk);
    srst <= 1'b0;
    for (int i = 0; i < 6; i++) rd_chk(ra[i], rr[i]);
    check({31'h0, rf_sample_clock_en}, 32'h1, "rf sample enable");
    host.wr(12'h100, 8'h5A);
    rd_chk(12'h100, 8'h00);
    host.wr(CDCK_HOST_FIRST, 8'hA5);
    host.wr(CDCK_HOST_LAST, 8'h3C);
    rd_chk(CDCK_HOST_FIRST, 8'hA5);
    rd_chk(CDCK_HOST_LAST, 8'h3C);
    for (int d = 0; d < 4; d++) begin
      host.wr(CDCK_ADDR_CORE, 8'(d));
      rd_chk(CDCK_ADDR_CORE, 8'(d));
      measure(64);
      check(32'(c_core), 32'(64 >> (d + 1)), "core pulses");
    end
    measure(20);
    check(32'(c_pll), 32'd20, "pll ref full");
    host.wr(CDCK_ADDR_PLL, 8'h01);
    measure(20);
    check({31'h0, crystal_16m_select}, 32'h1, "16m select");
    check(32'(c_pll), 32'd10, "pll ref halved");
    @(posedge mclk);
    xtal_ref <= 1'b0;
    measure(20);
    check(32'(c_pll), 32'd0, "pll ref stopped");
    @(posedge mclk);
    xtal_ref <= 1'b1;
    measure(192);
    check(32'(c_bit), 32'd4, "bit clock pulses");
    host.wr(CDCK_ADDR_BITCLK, 8'h97);
    measure(96);
    check(32'(c_bit + c_bo), 32'd0, "gated bit clock");
    host.wr(CDCK_ADDR_SERIAL, 8'h02);
    ext_run <= 1'b1;
    rx_chk <= 1'b1;
    measure(60);
    check(32'(rx_err), 32'd0, "rx bit clock follow");
    check(32'(c_bo), 32'd20, "rx bit clock edges");
    rx_chk <= 1'b0;
    host.wr(CDCK_ADDR_SERIAL, 8'h01);
    measure(48);
    check({31'h0, spdif_enable}, 32'h1, "spdif on");
    check(32'(c_sp), 32'd4, "spdif pulses");
    host.wr(CDCK_ADDR_SERIAL, 8'h00);
    measure(48);
    check({31'h0, spdif_enable}, 32'h0, "spdif off");
    check(32'(c_sp), 32'd0, "spdif idle");
    host.wr(CDCK_ADDR_DEBUG, 8'h31);
    measure(64);
    check(32'(c_dbg), 32'd32, "debug clock edges");
    check(32'(c_dac), 32'd16, "dac clock edges");
    host.wr(CDCK_ADDR_CORE, 8'h80);
    measure(64);
    check({31'h0, sleep_state}, 32'h1, "sleep");
    check(32'(c_core + c_dbg + c_dac), 32'd0, "sleep clocks");
    rd_chk(CDCK_ADDR_STATUS, 8'h04);
    print_verdict();
  end
endmodule : tb_top
